/* File: pwc_pkg.sv */
// shared constants, types and decode helper for the primary word decoder
package pwc_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          WORD_W         = 16;
  localparam int          DAC_W          = 14;
  localparam int          STEP_W         = 8;
  localparam int          PERIOD_W       = 16;
  localparam int          FIFO_DEPTH     = 32;

  // register byte addresses
  localparam logic [7:0]  OFS_PERIOD     = 8'h00;
  localparam logic [7:0]  OFS_STEP       = 8'h04;
  localparam logic [7:0]  OFS_ADC        = 8'h08;
  localparam logic [7:0]  OFS_DAC        = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;

  // status fields, and the valid bit of the converter word
  localparam int          ST_EMPTY       = 0;
  localparam int          ST_FULL        = 1;
  localparam int          ST_OVERFLOW    = 2;
  localparam int          ST_DELAY       = 3;
  localparam int          ST_ADVANCE     = 4;
  localparam int          ST_SECONDARY   = 5;
  localparam int          ST_LEVEL       = 8;
  localparam int          DAC_VALID_BIT  = 16;

  // values after reset, and the index of the last bit of a frame
  localparam logic [15:0] PERIOD_RST     = 16'h0400;
  localparam logic [7:0]  STEP_RST       = 8'h00;
  localparam logic [15:0] ADC_RST        = 16'h0000;
  localparam logic [3:0]  BITS_LAST      = 4'hf;

  // secondary frame sync pulse width
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          SEC_PULSE_NS   = 800;
  localparam int          SEC_PULSE_CYC  = (SEC_PULSE_NS / CLK_PERIOD_NS) < 1
                                           ? 1 : SEC_PULSE_NS / CLK_PERIOD_NS;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_DECERR    = 2'b11;

  typedef enum logic [0:0] {
    FRM_IDLE  = 1'b0,
    FRM_SHIFT = 1'b1
  } pwc_frame_e;

  typedef struct packed {
    logic delay;
    logic advance;
    logic secondary;
  } pwc_cmd_s;

  typedef struct packed {
    logic [DAC_W-1:0] dac;
    logic             word_ctl_hi;
    logic             word_ctl_lo;
  } pwc_word_s;

  // combinations outside the table decode to no action
  function automatic pwc_cmd_s decode_cmd(input logic word_ctl_hi,
                                          input logic word_ctl_lo,
                                          input logic func_pin_hi,
                                          input logic func_pin_lo);
    pwc_cmd_s c;
    c = '0;
    unique case ({word_ctl_hi, word_ctl_lo, func_pin_hi, func_pin_lo})
      4'h1:    c.delay     = 1'b1;
      4'h2:    c.advance   = 1'b1;
      4'h3:    c.secondary = 1'b1;
      4'h4:    c.delay     = 1'b1;
      4'h8:    c.advance   = 1'b1;
      4'hc:    c.secondary = 1'b1;
      default: c = '0;
    endcase
    return c;
  endfunction

endpackage

/* File: pwc_decoder.sv */
// serial primary word link, sample timer, fifo and axi4-lite registers
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module pwc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_reset,
  input  wire logic                     i_in_valid,
  output wire logic                     o_in_ready,
  input  wire logic [WIDTH-1:0]         i_in_data,
  output wire logic                     o_out_valid,
  input  wire logic                     i_out_ready,
  output wire logic [WIDTH-1:0]         o_out_data,
  output wire logic [$clog2(DEPTH):0]   o_level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push = i_in_valid & o_in_ready;
  wire              pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = count_reg != PW'(0) + (PW+1)'(DEPTH);
  assign o_out_valid = count_reg != '0;
  assign o_out_data  = mem[rd_ptr_reg];
  assign o_level     = count_reg;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)  rd_ptr_reg <= rd_ptr_reg + PW'(1);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // pwc_fifo

////////////////////////////////////////////////////////////////////////////
module pwc_decoder #(
  parameter int FIFO_W = pwc_pkg::DAC_W,
  parameter int FIFO_D = pwc_pkg::FIFO_DEPTH
) (
  input  wire logic                       I_CLOCK,
  input  wire logic                       I_RESET,
  // serial link pins
  input  wire logic                       I_SHIFT_CLK,
  input  wire logic                       I_FRAME_SYNC_N,
  input  wire logic                       I_SERIAL_IN,
  input  wire logic                       I_FUNC_PIN_HI,
  input  wire logic                       I_FUNC_PIN_LO,
  output logic                            O_SERIAL_OUT,
  output logic                            O_SERIAL_OUT_EN,
  output logic                            O_SEC_FRAME_SYNC_N,
  output logic                            O_SAMPLE_TICK,
  // axi4-lite slave
  input  wire logic                       I_AWVALID,
  output logic                            O_AWREADY,
  input  wire logic [pwc_pkg::ADDR_W-1:0] I_AWADDR,
  input  wire logic                       I_WVALID,
  output logic                            O_WREADY,
  input  wire logic [31:0]                I_WDATA,
  input  wire logic [3:0]                 I_WSTRB,
  output logic                            O_BVALID,
  input  wire logic                       I_BREADY,
  output logic [1:0]                      O_BRESP,
  input  wire logic                       I_ARVALID,
  output logic                            O_ARREADY,
  input  wire logic [pwc_pkg::ADDR_W-1:0] I_ARADDR,
  output logic                            O_RVALID,
  input  wire logic                       I_RREADY,
  output logic [31:0]                     O_RDATA,
  output logic [1:0]                      O_RRESP
);
  import pwc_pkg::*;

  localparam int LW = $clog2(FIFO_D) + 1;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic       sclk_s3_reg;
  logic       fs_s3_reg;

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      pin_s1_reg  <= 5'h03;
      pin_s2_reg  <= 5'h03;
      sclk_s3_reg <= 1'b1;
      fs_s3_reg   <= 1'b1;
    end else begin
      pin_s1_reg  <= {I_FUNC_PIN_HI, I_FUNC_PIN_LO, I_SERIAL_IN,
                      I_FRAME_SYNC_N, I_SHIFT_CLK};
      pin_s2_reg  <= pin_s1_reg;
      sclk_s3_reg <= pin_s2_reg[0];
      fs_s3_reg   <= pin_s2_reg[1];
    end
  end

  wire sclk_rise    = pin_s2_reg[0] & ~sclk_s3_reg;
  wire sclk_fall    = ~pin_s2_reg[0] & sclk_s3_reg;
  wire frame_sync_fall = ~pin_s2_reg[1] & fs_s3_reg;
  wire din_bit      = pin_s2_reg[2];
  wire func_pin_lo  = pin_s2_reg[3];
  wire func_pin_hi  = pin_s2_reg[4];

  //////////////////////////////////////////////////////////////////////////
  // registers seen by software; the overflow flag and the last command are set by hardware
  logic [PERIOD_W-1:0]      period_reg;
  logic signed [STEP_W-1:0] step_reg;
  logic [WORD_W-1:0]        adc_reg;
  logic                     overflow_reg;
  pwc_cmd_s                 last_cmd_reg;

  //////////////////////////////////////////////////////////////////////////
  // serial frame engine
  pwc_frame_e        frame_reg;
  logic [WORD_W-1:0] tx_shift_reg;
  logic [WORD_W-1:0] rx_shift_reg;
  logic [3:0]        bit_cnt_reg;
  logic              got_fall_reg;
  logic              word_done_reg;

  wire       last_bit  = frame_reg == FRM_SHIFT && sclk_fall &&
                         bit_cnt_reg == BITS_LAST;
  wire [WORD_W-1:0] rx_next = {rx_shift_reg[WORD_W-2:0], din_bit};

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      frame_reg       <= FRM_IDLE;
      tx_shift_reg    <= '0;
      rx_shift_reg    <= '0;
      bit_cnt_reg     <= '0;
      got_fall_reg    <= 1'b0;
      word_done_reg   <= 1'b0;
      O_SERIAL_OUT    <= 1'b0;
      O_SERIAL_OUT_EN <= 1'b0;
    end else begin
      word_done_reg <= 1'b0;
      if (frame_sync_fall) begin
        // sample word is frozen at the frame start
        frame_reg       <= FRM_SHIFT;
        tx_shift_reg    <= {adc_reg[WORD_W-2:0], 1'b0};
        O_SERIAL_OUT    <= adc_reg[WORD_W-1];
        O_SERIAL_OUT_EN <= 1'b1;
        bit_cnt_reg     <= '0;
        got_fall_reg    <= 1'b0;
      end else if (frame_reg == FRM_SHIFT) begin
        if (sclk_rise && got_fall_reg) begin
          O_SERIAL_OUT <= tx_shift_reg[WORD_W-1];
          tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
        end
        if (sclk_fall) begin
          rx_shift_reg <= rx_next;
          bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          got_fall_reg <= 1'b1;
        end
        if (last_bit) begin
          frame_reg     <= FRM_IDLE;
          word_done_reg <= 1'b1;
        end
      end else if (sclk_rise) begin
        // line released one rising edge after the last bit
        O_SERIAL_OUT_EN <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // word decode and fifo of received converter words
  pwc_word_s  rx_word;
  pwc_cmd_s   cmd;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [LW-1:0]     fifo_level;
  logic       dac_pop;

  assign rx_word = pwc_word_s'(rx_shift_reg);
  assign cmd     = decode_cmd(rx_word.word_ctl_hi, rx_word.word_ctl_lo,
                              func_pin_hi, func_pin_lo);

  // upper fourteen bits only go to the converter path
  pwc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_clock     (I_CLOCK),
    .i_reset     (I_RESET),
    .i_in_valid  (word_done_reg),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (FIFO_W'(rx_word.dac)),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (dac_pop),
    .o_out_data  (fifo_out_data),
    .o_level     (fifo_level)
  );

  //////////////////////////////////////////////////////////////////////////
  // sample timer, one-shot phase shift and secondary frame request
  logic [PERIOD_W-1:0] sample_cnt_reg;
  logic                shift_pend_reg;
  logic [PERIOD_W:0]   shift_len_reg;
  logic [PERIOD_W-1:0] half_cnt_reg;
  logic                sec_arm_reg;
  logic [3:0]          sec_pulse_reg;

  // signed step keeps its sign, so a negative value flips the move
  wire signed [PERIOD_W+1:0] step_ext  = (PERIOD_W+2)'(step_reg);
  wire signed [PERIOD_W+1:0] base_ext  = {2'b00, period_reg};
  wire signed [PERIOD_W+1:0] shifted   = cmd.delay ? base_ext + step_ext
                                                   : base_ext - step_ext;
  wire [PERIOD_W:0] shift_clamped = shifted < 2
                                    ? (PERIOD_W+1)'(2)
                                    : shifted[PERIOD_W:0];
  wire              sample_due = sample_cnt_reg == '0;
  wire [PERIOD_W-1:0] reload   = shift_pend_reg
                                 ? PERIOD_W'(shift_len_reg - 1'b1)
                                 : period_reg - 1'b1;

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      sample_cnt_reg     <= PERIOD_RST;
      shift_pend_reg     <= 1'b0;
      shift_len_reg      <= '0;
      half_cnt_reg       <= '0;
      sec_arm_reg        <= 1'b0;
      sec_pulse_reg      <= '0;
      O_SAMPLE_TICK      <= 1'b0;
      O_SEC_FRAME_SYNC_N <= 1'b1;
    end else begin
      O_SAMPLE_TICK <= sample_due;
      if (sample_due) begin
        sample_cnt_reg <= reload;
        shift_pend_reg <= 1'b0;
      end else begin
        sample_cnt_reg <= sample_cnt_reg - 1'b1;
      end
      if (word_done_reg && (cmd.delay || cmd.advance)) begin
        shift_pend_reg <= 1'b1;
        shift_len_reg  <= shift_clamped;
      end
      if (frame_sync_fall) begin
        half_cnt_reg <= period_reg >> 1;
        sec_arm_reg  <= 1'b0;
      end else if (half_cnt_reg != '0) begin
        half_cnt_reg <= half_cnt_reg - 1'b1;
      end
      if (word_done_reg && cmd.secondary) begin
        sec_arm_reg <= 1'b1;
      end
      if (sec_arm_reg && half_cnt_reg == PERIOD_W'(1)) begin
        sec_pulse_reg      <= 4'(SEC_PULSE_CYC);
        sec_arm_reg        <= 1'b0;
        O_SEC_FRAME_SYNC_N <= 1'b0;
      end else if (sec_pulse_reg > 4'h1) begin
        sec_pulse_reg <= sec_pulse_reg - 4'h1;
      end else begin
        sec_pulse_reg      <= '0;
        O_SEC_FRAME_SYNC_N <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data taken in either order
  logic                aw_held_reg;
  logic                w_held_reg;
  logic [ADDR_W-1:0]   aw_addr_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;

  wire aw_take   = I_AWVALID & O_AWREADY;
  wire w_take    = I_WVALID & O_WREADY;
  wire wr_fire   = aw_held_reg & w_held_reg & ~O_BVALID;
  wire [7:0] wa  = 8'(aw_addr_reg) & 8'hfc;
  wire wr_period = wr_fire && wa == OFS_PERIOD;
  wire wr_step   = wr_fire && wa == OFS_STEP;
  wire wr_adc    = wr_fire && wa == OFS_ADC;
  wire wr_status = wr_fire && wa == OFS_STATUS;
  wire wr_hit    = wr_period | wr_step | wr_adc | wr_status;
  wire ovf_set   = word_done_reg & ~fifo_in_ready;
  wire ovf_clr   = wr_status & w_strb_reg[0] & w_data_reg[ST_OVERFLOW];

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      O_AWREADY   <= 1'b1;
      O_WREADY    <= 1'b1;
      O_BVALID    <= 1'b0;
      O_BRESP     <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= I_AWADDR;
        O_AWREADY   <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= I_WDATA;
        w_strb_reg <= I_WSTRB;
        O_WREADY   <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        O_BVALID    <= 1'b1;
        O_BRESP     <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  // byte lanes honoured for the multi-byte registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      period_reg   <= PERIOD_RST;
      step_reg     <= STEP_RST;
      adc_reg      <= ADC_RST;
      overflow_reg <= 1'b0;
      last_cmd_reg <= '0;
    end else begin
      if (wr_period && w_strb_reg[0]) period_reg[7:0]  <= w_data_reg[7:0];
      if (wr_period && w_strb_reg[1]) period_reg[15:8] <= w_data_reg[15:8];
      if (wr_step && w_strb_reg[0])   step_reg         <= w_data_reg[7:0];
      if (wr_adc && w_strb_reg[0])    adc_reg[7:0]     <= w_data_reg[7:0];
      if (wr_adc && w_strb_reg[1])    adc_reg[15:8]    <= w_data_reg[15:8];
      // a new overflow in the clearing cycle wins
      if (ovf_set)      overflow_reg <= 1'b1;
      else if (ovf_clr) overflow_reg <= 1'b0;
      if (word_done_reg) last_cmd_reg <= cmd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite read side; reading the converter word pops the fifo
  wire ar_take  = I_ARVALID & O_ARREADY;
  wire [7:0] ra = 8'(I_ARADDR) & 8'hfc;
  assign dac_pop = ar_take && ra == OFS_DAC && fifo_out_valid;

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (ra)
      OFS_PERIOD: rd_word[PERIOD_W-1:0] = period_reg;
      OFS_STEP:   rd_word[STEP_W-1:0]   = step_reg;
      OFS_ADC:    rd_word[WORD_W-1:0]   = adc_reg;
      OFS_DAC: begin
        rd_word[FIFO_W-1:0]    = fifo_out_data;
        rd_word[DAC_VALID_BIT] = fifo_out_valid;
      end
      OFS_STATUS: begin
        rd_word[ST_EMPTY]     = ~fifo_out_valid;
        rd_word[ST_FULL]      = ~fifo_in_ready;
        rd_word[ST_OVERFLOW]  = overflow_reg;
        rd_word[ST_DELAY]     = last_cmd_reg.delay;
        rd_word[ST_ADVANCE]   = last_cmd_reg.advance;
        rd_word[ST_SECONDARY] = last_cmd_reg.secondary;
        rd_word[ST_LEVEL +: LW] = fifo_level;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= '0;
      O_RRESP   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        O_ARREADY <= 1'b0;
        O_RVALID  <= 1'b1;
        O_RDATA   <= rd_word;
        O_RRESP   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID  <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

endmodule // pwc_decoder

/* File: pwc_chk.sv */
// checker of link timing and bus answers at the decoder's ports
`timescale 1ns/100ps
module pwc_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_RESET,
  input wire logic        I_SHIFT_CLK,
  input wire logic        I_FRAME_SYNC_N,
  input wire logic        O_SERIAL_OUT,
  input wire logic        O_SERIAL_OUT_EN,
  input wire logic        O_SEC_FRAME_SYNC_N,
  input wire logic        O_SAMPLE_TICK,
  input wire logic        O_AWREADY,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  // clocks since a shift clock rise; a fall lands near 4
  logic [3:0] rise_age;
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) rise_age <= 4'hf;
    else if ($rose(I_SHIFT_CLK)) rise_age <= 4'h0;
    else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
  end
  //////////////////////////////////////////////////////////////////////////
  a_out_on_rise: assert property (
    $changed(O_SERIAL_OUT) && $past(O_SERIAL_OUT_EN) |-> rise_age < 4'h6)
    else $error("serial out moved off a shift clock rise");
  a_en_on_rise: assert property (
    $fell(O_SERIAL_OUT_EN) |-> rise_age < 4'h6)
    else $error("output enable dropped off a shift clock rise");
  a_frame_start: assert property (
    $fell(I_FRAME_SYNC_N) |-> ##[2:5] O_SERIAL_OUT_EN)
    else $error("frame start did not enable serial out");
  a_sec_width: assert property (
    $fell(O_SEC_FRAME_SYNC_N) |-> (!O_SEC_FRAME_SYNC_N) [*8]
    ##1 O_SEC_FRAME_SYNC_N) else $error("secondary sync width wrong");
  a_tick_single: assert property (O_SAMPLE_TICK |=> !O_SAMPLE_TICK)
    else $error("sample tick longer than one clock");
  a_b_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  a_r_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  a_r_answer: assert property (I_ARVALID && O_ARREADY |=>
    O_RVALID && !O_ARREADY) else $error("read not answered in time");
  a_r_decerr: assert property (O_RVALID && O_RRESP == 2'b11 |->
    O_RDATA == 32'h0) else $error("refused read returned data");
  a_aw_block: assert property (O_BVALID |-> !O_AWREADY)
    else $error("write taken during a write answer");
  c_sec: cover property ($fell(O_SEC_FRAME_SYNC_N));
  c_tick: cover property (O_SAMPLE_TICK);
  c_decerr: cover property (O_RVALID && O_RRESP == 2'b11);
endmodule // pwc_chk

/* File: pwc_host.sv */
// host serial port model: frame sync, shift clock and serial data
`timescale 1ns/100ps
module pwc_host (
  output logic      o_sclk,
  output logic      o_fs_n,
  output logic      o_din,
  input  wire logic i_dout
);
  // shift clock parks high between frames, it never runs free
  initial begin
    o_sclk = 1'b1;
    o_fs_n = 1'b1;
    o_din  = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // 16 bits each way, msb first, 800 ns a bit, phase off the master clock
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    #37;
    o_fs_n = 1'b0;
    o_din  = w[15];
    for (int i = 15; i >= 0; i--) begin
      #400;
      o_sclk = 1'b0;
      r[i]   = i_dout;
      o_fs_n = 1'b1;
      #400;
      o_sclk = 1'b1;
      // after the last bit the line toggles rather than hold a stale bit
      o_din  = (i > 0) ? w[i-1] : ~w[0];
    end
  endtask
endmodule // pwc_host

/* File: tb_top.sv */
// self-checking bench for the primary word decoder
`timescale 1ns/100ps
module tb_top;
  import pwc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, fp_hi = 1'b0, fp_lo = 1'b0, awv = 1'b0;
  logic wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0]  awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'h0;
  wire  logic  awrdy, wrdy, bvld, arrdy, rvld, sout, sen, sec, tick;
  wire  logic  sclk, fs_n, din;
  wire  logic [1:0]  br, rr;
  wire  logic [31:0] rdat;
  // a released serial line reads z, never a stale bit
  wire  logic  dout_w = sen ? sout : 1'bz;
  int          n_fail = 0, compares = 0;
  logic [15:0] rx;
  logic [31:0] d;
  logic [1:0]  r;
  logic [13:0] dv;
  time         t0, t1;
  // status {secondary, advance, delay} by {ctl hi, ctl lo, pin hi, pin lo}
  logic [2:0]  exp_cmd [16] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h1, 3'h0, 3'h0,
    3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0};
  logic [7:0]  ph_step [6] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'hf8, 8'h08};
  logic [3:0]  ph_cmd  [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h0};
  int          ph_dlt  [6] = '{8, -8, 8, -8, -8, 0};

  pwc_decoder i_dut (.I_CLOCK(clk), .I_RESET(rst), .I_SHIFT_CLK(sclk),
    .I_FRAME_SYNC_N(fs_n), .I_SERIAL_IN(din), .I_FUNC_PIN_HI(fp_hi),
    .I_FUNC_PIN_LO(fp_lo), .O_SERIAL_OUT(sout), .O_SERIAL_OUT_EN(sen),
    .O_SEC_FRAME_SYNC_N(sec), .O_SAMPLE_TICK(tick), .I_AWVALID(awv),
    .O_AWREADY(awrdy), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy),
    .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bvld), .I_BREADY(bre),
    .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arrdy), .I_ARADDR(ara),
    .O_RVALID(rvld), .I_RREADY(rre), .O_RDATA(rdat), .O_RRESP(rr));
  pwc_host i_host (.o_sclk(sclk), .o_fs_n(fs_n), .o_din(din),
    .i_dout(dout_w));

  initial forever #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= a;
    wd  <= v;
    ws  <= 4'hf;
    bre <= 1'b1;
    forever begin
      @(posedge clk);
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
      if (bvld === 1'b1) break;
    end
    r = br;
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    forever begin
      @(posedge clk);
      if (arrdy === 1'b1) arv <= 1'b0;
      if (rvld === 1'b1) break;
    end
    d = rdat;
    r = rr;
    rre <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
    rd(a);
    chk(d & m, e);
  endtask
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    i_host.frame(w, rx);
    repeat (4) @(posedge clk);
  endtask
  // sum of three sample intervals, starting at the next tick
  task automatic span(input int e);
    int n;
    int k;
    n = 0;
    k = 0;
    do @(posedge clk); while (tick !== 1'b1);
    while (k < 3) begin
      @(posedge clk);
      n++;
      if (tick === 1'b1) k++;
    end
    chk(32'(n), 32'(e));
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_PERIOD, 32'h0400, '1);
    rdc(OFS_STEP, 32'h0, '1);
    rdc(OFS_STATUS, 32'h1, 32'h3f07);
    rd(8'h14);
    chk(d, 32'h0);
    chk(32'(r), 32'h3);
    wr(8'h14, 32'h1);
    chk(32'(r), 32'h3);
    wr(OFS_ADC, 32'hc3a5);
    wr(OFS_PERIOD, 32'h0200);
    rdc(OFS_ADC, 32'hc3a5, '1);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      dv = 14'h2b6d ^ 14'(i * 37);
      fp_hi <= i[1];
      fp_lo <= i[0];
      send({dv, i[3], i[2]});
      chk(32'(rx), 32'hc3a5);
      rdc(OFS_STATUS, {26'h0, exp_cmd[i], 3'h0}, 32'h38);
      rdc(OFS_DAC, {15'h0, 1'b1, 2'h0, dv}, '1);
    end
    $display("test decode rows done");
    fp_hi <= 1'b0;
    fp_lo <= 1'b0;
    for (int i = 0; i < 33; i++) send({14'(i), 2'h0});
    rdc(OFS_STATUS, 32'h2006, 32'h3f07);
    for (int i = 0; i < 32; i++) rdc(OFS_DAC, {15'h1, 2'h0, 14'(i)}, '1);
    rdc(OFS_DAC, 32'h0, '1);
    wr(OFS_STATUS, 32'h4);
    rdc(OFS_STATUS, 32'h1, 32'h3f07);
    $display("test fifo done");
    for (int i = 0; i < 6; i++) begin
      wr(OFS_STEP, 32'(ph_step[i]));
      fp_hi <= ph_cmd[i][1];
      fp_lo <= ph_cmd[i][0];
      send({14'h0, ph_cmd[i][3:2]});
      span(3 * 512 + ph_dlt[i]);
    end
    $display("test phase shift done");
    fp_hi <= 1'b1;
    fp_lo <= 1'b1;
    fork
      send(16'h0);
      begin
        @(negedge fs_n) t0 = $time;
        @(negedge sec) t1 = $time;
      end
    join
    // half of 512 clocks plus the pin synchroniser lag
    chk(32'(t1 - t0 > 25700 && t1 - t0 < 26200), 32'h1);
    $display("test secondary done");
    give_verdict();
  end
  initial begin
    #4000000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // tb_top

bind pwc_decoder pwc_chk i_chk (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
  .I_SHIFT_CLK(I_SHIFT_CLK), .I_FRAME_SYNC_N(I_FRAME_SYNC_N),
  .O_SERIAL_OUT(O_SERIAL_OUT), .O_SERIAL_OUT_EN(O_SERIAL_OUT_EN),
  .O_SEC_FRAME_SYNC_N(O_SEC_FRAME_SYNC_N), .O_SAMPLE_TICK(O_SAMPLE_TICK),
  .O_AWREADY(O_AWREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
  .O_RRESP(O_RRESP));
